// >>> core/crdt_defs.vh
// crdt_defs.vh: register offsets, field positions, reset values, response codes
// assumes inclusion by the single timer core file
`ifndef CRDT_DEFS_VH
`define CRDT_DEFS_VH

`define CRDT_OFF_MODE      12'h0080
`define CRDT_OFF_PRESCALE  12'h0081
`define CRDT_OFF_PRIMARY   12'h0082
`define CRDT_OFF_SECONDARY 12'h0083
`define CRDT_OFF_WAVECTL   12'h0084
`define CRDT_OFF_SRC       12'h0088
`define CRDT_OFF_IRQ_STAT  12'h008C
`define CRDT_OFF_IRQ_EN    12'h0090
`define CRDT_OFF_IRQ_CLR   12'h0094

`define CRDT_MODE_RUN      7
`define CRDT_MODE_WC       6
`define CRDT_WAVE_OPL      5
`define CRDT_WAVE_TRIG     6
`define CRDT_WAVE_RW_MASK  8'hE0

`define CRDT_SRC_DIV1      2'h0
`define CRDT_SRC_DIV2      2'h1
`define CRDT_SRC_DIV8      2'h2
`define CRDT_SRC_NEIGHBOR  2'h3

`define CRDT_RST_BYTE      8'h00
`define CRDT_RESP_OKAY     2'h0
`define CRDT_RESP_SLVERR   2'h2

`define CRDT_IRQ_UNDERFLOW 0
`define CRDT_IRQ_EXT_TRIG  1

`endif

// >>> core/crdt_timer.v
// crdt_timer.v: cascaded reload down timer with axi4-lite register slave
// assumes synchronous inputs on i_clk_sys; registers 0x080 to 0x084 sit one byte apart, the rest on 32-bit aligned words
//
// How it works
// - count source is div1, div2, div8 or neighbour underflow pulse
// - prescaler decrements per source tick, primary per prescaler underflow; both reload on underflow automatically
// - primary counter reloads only from the primary reload register
// - prescaler underflow clocks primary; rate is source over (n+1)(m+1)
// - writing run bit to 1 starts counting
// - writing run bit to 0 halts, count held
// - secondary reload register never influences counting
// - trigger enable bit gates the external pin trigger
// - output level latch is read/write, resets to zero
// - each primary underflow sets irq status bit 0; the interrupt request rises only if enabled
// - reload write while stopped updates reload and counter together
// - running, wc=0: reload at tick 1, counter at tick 2, resume tick 3
// - wc=1: reload only; counter takes it at next underflow
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "crdt_defs.vh"

module crdt_timer #(
    parameter WIDTH = 8
) (
    input  wire        I_CLK_SYS,
    input  wire        I_RST_N,
    input  wire        i_neighbor_uf,
    input  wire        i_ext_pin,
    input  wire [11:0] i_awaddr,
    input  wire        i_awvalid,
    output reg         o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output reg         o_wready,
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    input  wire [11:0] i_araddr,
    input  wire        i_arvalid,
    output reg         o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    output reg         o_underflow,
    output reg         o_ext_trigger,
    output reg         o_irq
);

    function known_addr;
        input [11:0] a;
        begin
            known_addr = (a == `CRDT_OFF_MODE) || (a == `CRDT_OFF_PRESCALE) ||
                         (a == `CRDT_OFF_PRIMARY) || (a == `CRDT_OFF_SECONDARY) ||
                         (a == `CRDT_OFF_WAVECTL) || (a == `CRDT_OFF_SRC) ||
                         (a == `CRDT_OFF_IRQ_STAT) || (a == `CRDT_OFF_IRQ_EN) ||
                         (a == `CRDT_OFF_IRQ_CLR);
        end
    endfunction

    reg [7:0]       mode_reg;
    reg [7:0]       wave_reg;
    reg [1:0]       src_sel_reg;
    reg [WIDTH-1:0] pre_reload_reg;
    reg [WIDTH-1:0] pri_reload_reg;
    reg [WIDTH-1:0] sec_reload_reg;
    reg [WIDTH-1:0] pre_cnt_reg;
    reg [WIDTH-1:0] pri_cnt_reg;
    reg [1:0]       irq_stat_reg;
    reg [1:0]       irq_en_reg;
    reg [2:0]       div_reg;
    reg             ext_prev_reg;
    // pending running-write sequence (wc=0)
    reg [1:0]       pend_stage_reg;
    reg             pend_pre_reg;
    reg             pend_pri_reg;
    reg [WIDTH-1:0] pend_pre_val_reg;
    reg [WIDTH-1:0] pend_pri_val_reg;
    reg [11:0]      aw_addr_reg;
    reg             aw_held_reg;
    reg [31:0]      w_data_reg;
    reg             w_held_reg;
    // lane 0 strobe of the held write
    reg             w_strb_reg;

    wire run = mode_reg[`CRDT_MODE_RUN];
    wire wc  = mode_reg[`CRDT_MODE_WC];

    reg tick;
    always @* begin
        case (src_sel_reg)
            `CRDT_SRC_DIV1: tick = 1'b1;
            `CRDT_SRC_DIV2: tick = div_reg[0];
            `CRDT_SRC_DIV8: tick = (div_reg == 3'h7);
            default:        tick = i_neighbor_uf;
        endcase
    end

    // write decode: a register changes on the edge that raises bvalid
    // aw and w are held separately, so either order works
    wire [11:0] wa    = aw_addr_reg;
    wire [31:0] wd    = w_data_reg;
    wire        do_wr = aw_held_reg & w_held_reg & ~o_bvalid;
    // byte lane 0 carries every register; a write without it is dropped
    wire        wr_b0   = do_wr & w_strb_reg;
    wire        wr_mode = wr_b0 & (wa == `CRDT_OFF_MODE);
    wire        wr_pre  = wr_b0 & (wa == `CRDT_OFF_PRESCALE);
    wire        wr_pri  = wr_b0 & (wa == `CRDT_OFF_PRIMARY);
    wire        wr_sec  = wr_b0 & (wa == `CRDT_OFF_SECONDARY);
    wire        wr_wave = wr_b0 & (wa == `CRDT_OFF_WAVECTL);
    wire        wr_src  = wr_b0 & (wa == `CRDT_OFF_SRC);
    wire        wr_en   = wr_b0 & (wa == `CRDT_OFF_IRQ_EN);
    wire        wr_clr  = wr_b0 & (wa == `CRDT_OFF_IRQ_CLR);

    // bits of the irq status that a clear write drops
    function [1:0] clr_mask;
        input       sel;
        input [1:0] d;
        begin
            clr_mask = sel ? d : 2'h0;
        end
    endfunction

    wire pre_uf = run & tick & (pend_stage_reg != 2'h2) & (pre_cnt_reg == {WIDTH{1'b0}});
    wire pri_uf = pre_uf & (pri_cnt_reg == {WIDTH{1'b0}});
    wire trig   = wave_reg[`CRDT_WAVE_TRIG] & i_ext_pin & ~ext_prev_reg;
    // status with this cycle's events and clear applied; a set beats a clear
    wire [1:0] irq_stat_next = (irq_stat_reg & ~clr_mask(wr_clr, wd[1:0])) | {trig, pri_uf};

    // read-back word for an address; prescale and primary reload ports show the live count
    function [31:0] rd_word;
        input [11:0] a;
        begin
            case (a)
                `CRDT_OFF_MODE:      rd_word = {24'h00_0000, mode_reg};
                `CRDT_OFF_PRESCALE:  rd_word = {{(32-WIDTH){1'b0}}, pre_cnt_reg};
                `CRDT_OFF_PRIMARY:   rd_word = {{(32-WIDTH){1'b0}}, pri_cnt_reg};
                `CRDT_OFF_SECONDARY: rd_word = {{(32-WIDTH){1'b0}}, sec_reload_reg};
                `CRDT_OFF_WAVECTL:   rd_word = {24'h00_0000, wave_reg};
                `CRDT_OFF_SRC:       rd_word = {30'h0000_0000, src_sel_reg};
                `CRDT_OFF_IRQ_STAT:  rd_word = {30'h0000_0000, irq_stat_reg};
                `CRDT_OFF_IRQ_EN:    rd_word = {30'h0000_0000, irq_en_reg};
                default:             rd_word = 32'h0000_0000;
            endcase
        end
    endfunction

    always @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pre_reload_reg   <= {WIDTH{1'b0}};
            pri_reload_reg   <= {WIDTH{1'b0}};
            pre_cnt_reg      <= {WIDTH{1'b0}};
            pri_cnt_reg      <= {WIDTH{1'b0}};
            pend_stage_reg   <= 2'h0;
            pend_pre_reg     <= 1'b0;
            pend_pri_reg     <= 1'b0;
            pend_pre_val_reg <= {WIDTH{1'b0}};
            pend_pri_val_reg <= {WIDTH{1'b0}};
            o_underflow      <= 1'b0;
        end else begin
            o_underflow   <= pri_uf;
            // counting path
            if (run && tick) begin
                if (pend_stage_reg == 2'h1) begin
                    if (pend_pre_reg) pre_reload_reg <= pend_pre_val_reg;
                    if (pend_pri_reg) pri_reload_reg <= pend_pri_val_reg;
                    pend_stage_reg <= 2'h2;
                end else if (pend_stage_reg == 2'h2) begin
                    pre_cnt_reg    <= pre_reload_reg;
                    pri_cnt_reg    <= pri_reload_reg;
                    pend_stage_reg <= 2'h0;
                    pend_pre_reg   <= 1'b0;
                    pend_pri_reg   <= 1'b0;
                end else if (pre_uf) begin
                    pre_cnt_reg <= pre_reload_reg;
                    if (pri_uf)
                        pri_cnt_reg <= pri_reload_reg;
                    else
                        pri_cnt_reg <= pri_cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
                end else begin
                    pre_cnt_reg <= pre_cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
            if (wr_pre || wr_pri) begin
                if (!run) begin
                    if (wr_pre) pre_reload_reg <= wd[WIDTH-1:0];
                    if (wr_pre) pre_cnt_reg    <= wd[WIDTH-1:0];
                    if (wr_pri) pri_reload_reg <= wd[WIDTH-1:0];
                    if (wr_pri) pri_cnt_reg    <= wd[WIDTH-1:0];
                end else if (wc) begin
                    if (wr_pre) pre_reload_reg <= wd[WIDTH-1:0];
                    if (wr_pri) pri_reload_reg <= wd[WIDTH-1:0];
                end else begin
                    pend_stage_reg <= 2'h1;
                    if (wr_pre) pend_pre_reg     <= 1'b1;
                    if (wr_pre) pend_pre_val_reg <= wd[WIDTH-1:0];
                    if (wr_pri) pend_pri_reg     <= 1'b1;
                    if (wr_pri) pend_pri_val_reg <= wd[WIDTH-1:0];
                end
            end
        end
    end

    // software-written control bytes
    always @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            mode_reg       <= `CRDT_RST_BYTE;
            wave_reg       <= `CRDT_RST_BYTE;
            src_sel_reg    <= `CRDT_SRC_DIV1;
            sec_reload_reg <= {WIDTH{1'b0}};
        end else begin
            if (wr_mode) mode_reg <= wd[7:0];
            // kept for read-back only, never reaches the counters
            if (wr_sec) sec_reload_reg <= wd[WIDTH-1:0];
            if (wr_wave) wave_reg <= wd[7:0] & `CRDT_WAVE_RW_MASK;
            if (wr_src) src_sel_reg <= wd[1:0];
        end
    end

    // free divider taps and external pin edge detect
    // div2 ticks on bit 0, div8 when the divider reads 7
    always @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            div_reg       <= 3'h0;
            ext_prev_reg  <= 1'b0;
            o_ext_trigger <= 1'b0;
        end else begin
            div_reg       <= div_reg + 3'h1;
            ext_prev_reg  <= i_ext_pin;
            o_ext_trigger <= trig;
        end
    end

    // sticky status and level interrupt
    // a new enable takes effect one edge after it is written
    always @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            irq_stat_reg <= 2'h0;
            irq_en_reg   <= 2'h0;
            o_irq        <= 1'b0;
        end else begin
            if (wr_en) irq_en_reg <= wd[1:0];
            irq_stat_reg <= irq_stat_next;
            o_irq        <= |(irq_stat_next & irq_en_reg);
        end
    end

    // axi4-lite handshakes: one write, one read at a time
    always @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            o_awready   <= 1'b0;
            o_wready    <= 1'b0;
            o_bvalid    <= 1'b0;
            o_bresp     <= `CRDT_RESP_OKAY;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= 12'h000;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 1'b0;
        end else begin
            o_awready <= ~aw_held_reg & ~(i_awvalid & o_awready) & ~o_bvalid;
            o_wready  <= ~w_held_reg & ~(i_wvalid & o_wready) & ~o_bvalid;
            if (i_awvalid && o_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= i_wdata;
                w_strb_reg <= i_wstrb[0];
            end
            if (aw_held_reg && w_held_reg && !o_bvalid) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                o_bvalid    <= 1'b1;
                o_bresp     <= known_addr(aw_addr_reg) ? `CRDT_RESP_OKAY : `CRDT_RESP_SLVERR;
                o_awready   <= 1'b0;
                o_wready    <= 1'b0;
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // read channel: address taken, word answered on the next edge
    // answer held until rready is seen
    always @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= `CRDT_RESP_OKAY;
        end else begin
            o_arready <= ~o_arready & ~o_rvalid & i_arvalid;
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rresp  <= known_addr(i_araddr) ? `CRDT_RESP_OKAY : `CRDT_RESP_SLVERR;
                o_rdata  <= rd_word(i_araddr);
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

endmodule

// >>> sim/crdt_timer_asserts.sv
// crdt_timer_asserts.sv: port-level checks of the reload timer
// assumes binding into crdt_timer; one clock, async active-low reset
`timescale 1ns/1ps
module crdt_chk (
    input wire logic        I_CLK_SYS,
    input wire logic        I_RST_N,
    input wire logic        i_ext_pin,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic        o_underflow,
    input wire logic        o_ext_trigger,
    input wire logic        o_irq
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    property p_rst; $rose(I_RST_N) |-> !o_irq && !o_underflow && !o_bvalid; endproperty
    a_rst: assert property (p_rst) else $error("outputs busy after reset");
    property p_b_hold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response not held");
    property p_r_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    property p_r_hi; o_rvalid |-> o_rdata[31:8] == 24'h00_0000; endproperty
    a_r_hi: assert property (p_r_hi) else $error("upper read bits set");
    property p_r_ans; i_arvalid && o_arready |=> o_rvalid; endproperty
    a_r_ans: assert property (p_r_ans) else $error("read answer late");
    property p_b_ans; i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid; endproperty
    a_b_ans: assert property (p_b_ans) else $error("write answer late");
    property p_no_aw; o_bvalid |-> !o_awready && !o_wready; endproperty
    a_no_aw: assert property (p_no_aw) else $error("write taken while busy");
    property p_rdy; o_awready && i_awvalid |=> !o_awready; endproperty
    a_rdy: assert property (p_rdy) else $error("address ready too long");
    property p_trig; o_ext_trigger |-> $past(i_ext_pin); endproperty
    a_trig: assert property (p_trig) else $error("trigger without pin");
    property p_trig1; o_ext_trigger |=> !o_ext_trigger; endproperty
    a_trig1: assert property (p_trig1) else $error("trigger not a pulse");
    c_uf: cover property (o_underflow);
    c_irq: cover property ($rose(o_irq));
    c_trig: cover property (o_ext_trigger);
    c_err: cover property (o_bvalid && o_bresp == 2'h2);
endmodule

bind crdt_timer crdt_chk crdt_chk_i (.I_CLK_SYS, .I_RST_N, .i_ext_pin, .i_awvalid, .o_awready,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata,
    .o_rvalid, .i_rready, .o_underflow, .o_ext_trigger, .o_irq);

// >>> sim/tb_crdt_timer.sv
// tb_crdt_timer.sv: self-checking bench of the reload timer over axi4-lite
// assumes crdt_timer with byte-addressed registers, 100 MHz clock
`timescale 1ns/1ps
module tb_crdt_timer;
    reg         I_CLK_SYS = 0, I_RST_N = 0, i_neighbor_uf = 0, i_ext_pin = 0;
    reg  [11:0] i_awaddr = 0, i_araddr = 0;
    reg  [31:0] i_wdata = 0;
    reg  [3:0]  i_wstrb = 4'hF;
    reg         i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
    wire        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    wire        o_underflow, o_ext_trigger, o_irq;
    wire [1:0]  o_bresp, o_rresp;
    wire [31:0] o_rdata;
    int         err_count = 0, cmp_count = 0, tcnt = 0, nbc = 0, k, p, n, m, s;
    reg  [7:0]  rv, r2;
    reg  [1:0]  rsp;
    bit  [11:0] ra [5] = '{12'h080, 12'h081, 12'h082, 12'h084, 12'h08C};

    crdt_timer crdt_timer_i (.I_CLK_SYS, .I_RST_N, .i_neighbor_uf, .i_ext_pin, .i_awaddr,
        .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
        .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready,
        .o_underflow, .o_ext_trigger, .o_irq);

    always #5 I_CLK_SYS = ~I_CLK_SYS;
    // neighbour underflow: one-cycle pulse every third cycle
    always @(posedge I_CLK_SYS) begin
        nbc <= (nbc == 2) ? 0 : nbc + 1;
        i_neighbor_uf <= (nbc == 1);
        if (o_ext_trigger) tcnt <= tcnt + 1;
    end

    task chk(input [31:0] seen, input [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task results;
        $display("mismatches=%0d compares=%0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task tmo;
        err_count++;
        results;
    endtask
    task wr(input [11:0] a, input [7:0] d);
        bit done;
        done = 0;
        @(posedge I_CLK_SYS);
        i_awaddr <= a;
        i_wdata <= {24'h00_0000, d};
        i_awvalid <= 1'h1;
        i_wvalid <= 1'h1;
        i_bready <= 1'h1;
        for (k = 0; k < 40 && !done; k++) begin
            @(posedge I_CLK_SYS);
            if (i_awvalid && o_awready) i_awvalid <= 1'h0;
            if (i_wvalid && o_wready) i_wvalid <= 1'h0;
            if (o_bvalid) begin
                done = 1;
                i_bready <= 1'h0;
                rsp = o_bresp;
            end
        end
        if (!done) tmo;
    endtask
    task rd(input [11:0] a);
        bit done;
        done = 0;
        @(posedge I_CLK_SYS);
        i_araddr <= a;
        i_arvalid <= 1'h1;
        i_rready <= 1'h1;
        for (k = 0; k < 40 && !done; k++) begin
            @(posedge I_CLK_SYS);
            if (i_arvalid && o_arready) i_arvalid <= 1'h0;
            if (o_rvalid) begin
                done = 1;
                i_rready <= 1'h0;
                rv = o_rdata[7:0];
                rsp = o_rresp;
            end
        end
        if (!done) tmo;
    endtask
    // cycles between two underflow pulses
    task meas(output int c);
        for (k = 0; k < 3000 && !o_underflow; k++) @(posedge I_CLK_SYS);
        if (k >= 3000) tmo;
        c = 0;
        do begin
            @(posedge I_CLK_SYS);
            c++;
        end while (!o_underflow && c < 3000);
        if (c >= 3000) tmo;
    endtask
    task pulse;
        repeat (2) @(posedge I_CLK_SYS);
        i_ext_pin <= 1'h1;
        repeat (4) @(posedge I_CLK_SYS);
        i_ext_pin <= 1'h0;
        repeat (4) @(posedge I_CLK_SYS);
    endtask
    function int per(int src, int pn, int pm);
        per = (pn + 1) * (pm + 1) * ((src == 0) ? 1 : (src == 1) ? 2 : (src == 2) ? 8 : 3);
    endfunction

    initial begin
        void'($urandom(32'h3719));
        repeat (4) @(posedge I_CLK_SYS);
        I_RST_N <= 1'h1;
        foreach (ra[i]) begin
            rd(ra[i]);
            chk(rv, 8'h00);
        end
        for (s = 0; s < 4; s++) begin
            r2 = (s == 0) ? 8'hFF : 8'($urandom);
            wr(12'h084, r2);
            rd(12'h084);
            chk(rv, r2 & 8'hE0);
        end
        wr(12'h084, 8'h00);
        pulse;
        chk(tcnt, 0);
        wr(12'h084, 8'h40);
        pulse;
        chk(tcnt, 1);
        rd(12'h0A0);
        chk(rsp, 2'h2);
        wr(12'h090, 8'h01);
        for (s = 0; s < 4; s++) begin
            n = (s == 0) ? 0 : $urandom % 5;
            m = $urandom % 5;
            wr(12'h088, 8'(s));
            wr(12'h081, 8'(n));
            rd(12'h081);
            chk(rv, n);
            wr(12'h082, 8'(m));
            wr(12'h083, 8'($urandom));
            wr(12'h080, 8'h80);
            meas(p);
            meas(p);
            chk(p, per(s, n, m));
            chk(o_irq, 1'h1);
            wr(12'h080, 8'h00);
            wr(12'h094, 8'h01);
            chk(o_irq, 1'h0);
            rd(12'h082);
            r2 = rv;
            repeat (20) @(posedge I_CLK_SYS);
            rd(12'h082);
            chk(rv, r2);
        end
        wr(12'h090, 8'h00);
        wr(12'h080, 8'h80);
        meas(p);
        chk(o_irq, 1'h0);
        rd(12'h08C);
        chk(rv[0], 1'h1);
        wr(12'h080, 8'h00);
        wr(12'h088, 8'h00);
        wr(12'h081, 8'h00);
        wr(12'h082, 8'h04);
        wr(12'h080, 8'hC0);
        meas(p);
        meas(p);
        chk(p, per(0, 0, 4));
        wr(12'h082, 8'h02);
        meas(p);
        meas(p);
        chk(p, per(0, 0, 2));
        wr(12'h080, 8'h80);
        wr(12'h082, 8'h01);
        meas(p);
        meas(p);
        chk(p, per(0, 0, 1));
        results;
    end
    initial begin
        repeat (90000) @(posedge I_CLK_SYS);
        tmo;
    end
endmodule
